// ---- design/drs_dma.sv ----
/*
 * Four-channel DMA engine with buffered reload registers, software and
 * peripheral starts, forced termination, fixed timing and CPU bus hold.
 * Assumes an APB master on pclk, peripheral request pulses on pclk,
 * two asynchronous external pin requests, and a memory port whose read
 * data is valid in the last cycle of a read access.
 */
// The address map and the APB interface to the registers were left to the implementer.

`timescale 1ns/100ps
`default_nettype none

module drs_dma #(
	parameter int NOISE_CLKS = drs_pkg::NOISE_CLKS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [63:0] periph_irq,
	input  wire logic [1:0]  external_pin_interrupt,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [15:0] mem_wdata,
	output logic             mem_periph,
	input  wire logic [15:0] mem_rdata,
	output logic             cpu_ram_stall,
	output logic             cpu_periph_stall,
	output logic      [3:0]  transfer_end_interrupt
);

	localparam int NB = drs_pkg::NCH * 5;

	drs_pkg::drs_state_t st_r;
	logic [1:0]  ch_r;
	logic [3:0]  cnt_r;
	logic [15:0] data_r;
	logic [3:0]  en_r;
	logic [3:0]  tc_r;
	logic [3:0]  act_r;
	logic [3:0]  pend_r;
	logic [6:0]  adc_r   [drs_pkg::NCH];
	logic [5:0]  tsel_r  [drs_pkg::NCH];
	logic [2:0]  wait_r;
	logic [15:0] slv     [NB];
	logic [15:0] upd_val [NB];
	logic [NB-1:0] buf_wr;
	logic [NB-1:0] buf_upd;
	logic [3:0]  sw_trig;
	logic [3:0]  hw_trig;
	logic [3:0]  init_p;
	logic [3:0]  tc_set;
	logic [3:0]  done_ch;
	logic [63:0] irq_src;
	logic [1:0]  ext_s1;
	logic [1:0]  ext_s2;
	logic [1:0]  filt_lvl;
	logic [1:0]  ext_edge;
	logic [7:0]  filt_cnt [2];

	////////////////////////////////////////////////////////////////////////
	// apb slave: no wait state; pready and read data are registered from the setup cycle

	logic        setup;
	logic        acc_done;
	logic        wr_ev;
	logic        rd_ev;
	logic [1:0]  a_ch;
	logic [4:0]  a_reg;
	logic        hit_ch;
	logic        hit_wait;
	logic [31:0] rd_val;

	assign setup    = psel && !penable;
	assign acc_done = psel && penable && pready;
	assign wr_ev    = acc_done && pwrite;
	assign rd_ev    = acc_done && !pwrite;
	assign a_ch     = paddr[6:5];
	assign a_reg    = paddr[4:0];
	assign hit_ch   = (paddr[11:7] == 5'h00);
	assign hit_wait = (paddr == drs_pkg::OFF_WAIT);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit_wait) begin
			rd_val[2:0] = wait_r;
		end else if (hit_ch) begin
			case (a_reg)
			drs_pkg::OFF_SRC_HI: rd_val[15:0] = slv[a_ch*5+0];
			drs_pkg::OFF_SRC_LO: rd_val[15:0] = slv[a_ch*5+1];
			drs_pkg::OFF_DST_HI: rd_val[15:0] = slv[a_ch*5+2];
			drs_pkg::OFF_DST_LO: rd_val[15:0] = slv[a_ch*5+3];
			drs_pkg::OFF_COUNT:  rd_val[15:0] = slv[a_ch*5+4];
			drs_pkg::OFF_CTRL: begin
				rd_val[drs_pkg::CTRL_EN_BIT] = en_r[a_ch];
				rd_val[drs_pkg::CTRL_TC_BIT] = tc_r[a_ch];
			end
			drs_pkg::OFF_ADC:  rd_val[6:0] = adc_r[a_ch];
			drs_pkg::OFF_TSEL: rd_val[5:0] = tsel_r[a_ch];
			default:           rd_val = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup && !pready;
			pslverr <= setup && !pready && !(hit_ch || hit_wait);
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external pins: synchronise, then accept only a level held steady

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1 <= 2'b00;
			ext_s2 <= 2'b00;
		end else begin
			ext_s1 <= external_pin_interrupt;
			ext_s2 <= ext_s1;
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_filt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				filt_cnt[p] <= 8'h00;
				filt_lvl[p] <= 1'b0;
				ext_edge[p] <= 1'b0;
			end else begin
				ext_edge[p] <= 1'b0;
				if (ext_s2[p] == filt_lvl[p]) begin
					filt_cnt[p] <= 8'h00;
				end else if (filt_cnt[p] == 8'(NOISE_CLKS - 1)) begin
					filt_cnt[p] <= 8'h00;
					filt_lvl[p] <= ext_s2[p];
					ext_edge[p] <= ext_s2[p];
				end else begin
					filt_cnt[p] <= filt_cnt[p] + 8'h01;
				end
			end
		end
	end

	always_comb begin
		irq_src = periph_irq;
		irq_src[drs_pkg::EXT_CODE0] = ext_edge[0];
		irq_src[drs_pkg::EXT_CODE1] = ext_edge[1];
		irq_src[drs_pkg::TSEL_NONE] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel control, triggers and completion

	logic       unit_done;
	logic       abort;
	logic       last_unit;
	logic       pick_v;
	logic [1:0] pick_ch;

	for (genvar c = 0; c < drs_pkg::NCH; c++) begin : g_ch
		logic ctrl_wr;
		assign ctrl_wr = wr_ev && hit_ch && a_ch == 2'(c)
			&& a_reg == drs_pkg::OFF_CTRL;
		assign init_p[c] = ctrl_wr && pwdata[drs_pkg::CTRL_INIT_BIT];
		assign sw_trig[c] = ctrl_wr && pwdata[drs_pkg::CTRL_STG_BIT]
			&& pwdata[drs_pkg::CTRL_EN_BIT] && !tc_r[c];
		assign hw_trig[c] = tsel_r[c] != drs_pkg::TSEL_NONE
			&& irq_src[tsel_r[c]] && en_r[c] && !tc_r[c];
		assign tc_set[c] = unit_done && last_unit && ch_r == 2'(c);
		assign done_ch[c] = tc_set[c] || init_p[c];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				en_r[c]   <= 1'b0;
				adc_r[c]  <= drs_pkg::RST_ADC;
				tsel_r[c] <= drs_pkg::RST_TSEL;
			end else if (wr_ev && hit_ch && a_ch == 2'(c)) begin
				if (a_reg == drs_pkg::OFF_CTRL) begin
					en_r[c] <= pwdata[drs_pkg::CTRL_EN_BIT];
				end
				if (a_reg == drs_pkg::OFF_ADC) begin
					adc_r[c] <= pwdata[6:0];
				end
				if (a_reg == drs_pkg::OFF_TSEL) begin
					tsel_r[c] <= pwdata[5:0];
				end
			end
		end

		// set beats the read-clear in the same cycle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tc_r[c] <= 1'b0;
			end else if (tc_set[c]) begin
				tc_r[c] <= 1'b1;
			end else if (rd_ev && hit_ch && a_ch == 2'(c)
				&& a_reg == drs_pkg::OFF_CTRL
				&& prdata[drs_pkg::CTRL_TC_BIT]) begin
				tc_r[c] <= 1'b0;
			end
		end

		// completion or a forced stop beats a start in the same cycle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				act_r[c]  <= 1'b0;
				pend_r[c] <= 1'b0;
			end else if (done_ch[c]) begin
				act_r[c]  <= 1'b0;
				pend_r[c] <= 1'b0;
			end else if (sw_trig[c] || hw_trig[c]) begin
				act_r[c]  <= 1'b1;
				pend_r[c] <= 1'b1;
			end else if (st_r == drs_pkg::ST_IDLE && pick_v
				&& pick_ch == 2'(c)) begin
				pend_r[c] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffered address and count registers

	logic [31:0] src_cur;
	logic [31:0] dst_cur;
	logic [31:0] src_nxt;
	logic [31:0] dst_nxt;
	logic [15:0] cnt_cur;
	logic [6:0]  adc_cur;

	assign src_cur   = {slv[ch_r*5+0], slv[ch_r*5+1]};
	assign dst_cur   = {slv[ch_r*5+2], slv[ch_r*5+3]};
	assign cnt_cur   = slv[ch_r*5+4];
	assign adc_cur   = adc_r[ch_r];
	assign last_unit = cnt_cur <= 16'h0001;

	always_comb begin
		case (adc_cur[drs_pkg::ADC_SRC_DIR_LSB +: 2])
		drs_pkg::DIR_INC: src_nxt = src_cur + drs_pkg::UNIT_STEP;
		drs_pkg::DIR_DEC: src_nxt = src_cur - drs_pkg::UNIT_STEP;
		default:          src_nxt = src_cur;
		endcase
		case (adc_cur[drs_pkg::ADC_DST_DIR_LSB +: 2])
		drs_pkg::DIR_INC: dst_nxt = dst_cur + drs_pkg::UNIT_STEP;
		drs_pkg::DIR_DEC: dst_nxt = dst_cur - drs_pkg::UNIT_STEP;
		default:          dst_nxt = dst_cur;
		endcase
	end

	for (genvar i = 0; i < NB; i++) begin : g_buf
		localparam int C = i / 5;
		localparam int K = i % 5;
		assign buf_wr[i] = wr_ev && hit_ch && a_ch == 2'(C)
			&& a_reg == 5'(K * 4);
		assign buf_upd[i] = unit_done && ch_r == 2'(C);
		always_comb begin
			case (K)
			0:       upd_val[i] = src_nxt[31:16];
			1:       upd_val[i] = src_nxt[15:0];
			2:       upd_val[i] = dst_nxt[31:16];
			3:       upd_val[i] = dst_nxt[15:0];
			default: upd_val[i] = cnt_cur - 16'h0001;
			endcase
		end
		drs_buf #(.W(16)) u_buf (
			.pclk     (pclk),
			.presetn  (presetn),
			.wr       (buf_wr[i]),
			.wdata    (pwdata[15:0]),
			.active   (act_r[C]),
			.reload   (done_ch[C]),
			.upd      (buf_upd[i]),
			.upd_val  (upd_val[i]),
			.master_r (),
			.slave_r  (slv[i])
		);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= drs_pkg::RST_WAIT;
		end else if (wr_ev && hit_wait) begin
			wait_r <= pwdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer engine

	logic [3:0] src_len;
	logic [3:0] dst_len;
	logic       src_peri;
	logic       dst_peri;

	always_comb begin
		pick_v  = 1'b0;
		pick_ch = 2'd0;
		for (int k = drs_pkg::NCH - 1; k >= 0; k--) begin
			if (pend_r[k]) begin
				pick_v  = 1'b1;
				pick_ch = 2'(k);
			end
		end
	end

	assign src_peri = adc_cur[drs_pkg::ADC_SRC_PERI_BIT];
	assign dst_peri = adc_cur[drs_pkg::ADC_DST_PERI_BIT];
	assign src_len  = src_peri
		? 4'(drs_pkg::PERI_ACC_CLKS) + {1'b0, wait_r}
		: 4'(drs_pkg::RAM_ACC_CLKS);
	assign dst_len  = dst_peri
		? 4'(drs_pkg::PERI_ACC_CLKS) + {1'b0, wait_r}
		: 4'(drs_pkg::RAM_ACC_CLKS);
	assign abort     = st_r != drs_pkg::ST_IDLE && init_p[ch_r];
	assign unit_done = st_r == drs_pkg::ST_WRITE && cnt_r == 4'd0
		&& !abort;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r             <= drs_pkg::ST_IDLE;
			ch_r             <= 2'd0;
			cnt_r            <= 4'd0;
			data_r           <= 16'h0000;
			mem_req          <= 1'b0;
			mem_we           <= 1'b0;
			mem_addr         <= 32'h0000_0000;
			mem_wdata        <= 16'h0000;
			mem_periph       <= 1'b0;
			cpu_ram_stall    <= 1'b0;
			cpu_periph_stall <= 1'b0;
		end else if (abort) begin
			st_r             <= drs_pkg::ST_IDLE;
			mem_req          <= 1'b0;
			cpu_ram_stall    <= 1'b0;
			cpu_periph_stall <= 1'b0;
		end else begin
			case (st_r)
			drs_pkg::ST_IDLE: begin
				if (pick_v) begin
					st_r  <= drs_pkg::ST_RESP;
					ch_r  <= pick_ch;
					cnt_r <= 4'(drs_pkg::RESP_CLKS - 1);
				end
			end
			drs_pkg::ST_RESP: begin
				if (cnt_r == 4'd0) begin
					st_r       <= drs_pkg::ST_READ;
					cnt_r      <= src_len - 4'd1;
					mem_req    <= 1'b1;
					mem_we     <= 1'b0;
					mem_addr   <= {src_cur[31:1], 1'b0};
					mem_periph <= src_peri;
					// ram not named by the transfer stays open to the cpu
					cpu_ram_stall    <= !src_peri || !dst_peri;
					cpu_periph_stall <= src_peri || dst_peri;
				end else begin
					cnt_r <= cnt_r - 4'd1;
				end
			end
			drs_pkg::ST_READ: begin
				if (cnt_r == 4'd0) begin
					st_r    <= drs_pkg::ST_GAP;
					cnt_r   <= 4'(drs_pkg::GAP_CLKS - 1);
					data_r  <= mem_rdata;
					mem_req <= 1'b0;
				end else begin
					cnt_r <= cnt_r - 4'd1;
				end
			end
			drs_pkg::ST_GAP: begin
				if (cnt_r == 4'd0) begin
					st_r       <= drs_pkg::ST_WRITE;
					cnt_r      <= dst_len - 4'd1;
					mem_req    <= 1'b1;
					mem_we     <= 1'b1;
					mem_addr   <= {dst_cur[31:1], 1'b0};
					mem_wdata  <= data_r;
					mem_periph <= dst_peri;
				end else begin
					cnt_r <= cnt_r - 4'd1;
				end
			end
			drs_pkg::ST_WRITE: begin
				if (cnt_r != 4'd0) begin
					cnt_r <= cnt_r - 4'd1;
				end else if (!last_unit && adc_cur[drs_pkg::ADC_BLOCK_BIT])
				begin
					st_r       <= drs_pkg::ST_READ;
					cnt_r      <= src_len - 4'd1;
					mem_we     <= 1'b0;
					mem_addr   <= {src_nxt[31:1], 1'b0};
					mem_periph <= src_peri;
				end else begin
					st_r             <= drs_pkg::ST_IDLE;
					mem_req          <= 1'b0;
					mem_we           <= 1'b0;
					cpu_ram_stall    <= 1'b0;
					cpu_periph_stall <= 1'b0;
				end
			end
			default: st_r <= drs_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_end_interrupt <= 4'h0;
		end else begin
			transfer_end_interrupt <= tc_set;
		end
	end

endmodule

`default_nettype wire

// ---- design/drs_pkg.sv ----
/*
 * Shared constants for the four-channel DMA reload and start block:
 * register offsets, control field positions, reset values, timing counts
 * and the engine state type.
 * Assumes a 20 MHz pclk and a 32-bit APB register port.
 */
package drs_pkg;

	localparam int NCH = 4;

	// register offsets inside one channel window (word aligned bytes), then the full address of the wait register
	localparam logic [4:0]  OFF_SRC_HI = 5'h00;
	localparam logic [4:0]  OFF_SRC_LO = 5'h04;
	localparam logic [4:0]  OFF_DST_HI = 5'h08;
	localparam logic [4:0]  OFF_DST_LO = 5'h0C;
	localparam logic [4:0]  OFF_COUNT  = 5'h10;
	localparam logic [4:0]  OFF_CTRL   = 5'h14;
	localparam logic [4:0]  OFF_ADC    = 5'h18;
	localparam logic [4:0]  OFF_TSEL   = 5'h1C;
	localparam logic [11:0] OFF_WAIT   = 12'h080;

	// channel_control_register bits
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_INIT_BIT = 1;
	localparam int CTRL_STG_BIT  = 2;
	localparam int CTRL_TC_BIT   = 3;

	// addressing_control_register fields
	localparam int ADC_SRC_DIR_LSB  = 0;
	localparam int ADC_DST_DIR_LSB  = 2;
	localparam int ADC_SRC_PERI_BIT = 4;
	localparam int ADC_DST_PERI_BIT = 5;
	localparam int ADC_BLOCK_BIT    = 6;
	localparam logic [1:0] DIR_INC  = 2'b00;
	localparam logic [1:0] DIR_DEC  = 2'b01;

	// reset values
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [6:0]  RST_ADC  = 7'h00;
	localparam logic [5:0]  RST_TSEL = 6'h00;
	localparam logic [2:0]  RST_WAIT = 3'h0;

	// trigger codes
	localparam logic [5:0] TSEL_NONE = 6'h00;
	localparam logic [5:0] EXT_CODE0 = 6'h01;
	localparam logic [5:0] EXT_CODE1 = 6'h02;

	localparam logic [31:0] UNIT_STEP = 32'h0000_0002;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESP_CLKS     = 4;
	localparam int RAM_ACC_CLKS  = 2;
	localparam int PERI_ACC_CLKS = 4;
	localparam int GAP_CLKS      = 1;
	localparam int NOISE_TIME_NS = 200;
	localparam int NOISE_CLKS    =
		(NOISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RESP  = 3'b001,
		ST_READ  = 3'b011,
		ST_GAP   = 3'b010,
		ST_WRITE = 3'b110
	} drs_state_t;

endpackage

// ---- design/drs_buf.sv ----
/*
 * One two-stage buffered register: a master stage written by software
 * and a slave stage that the transfer engine uses and updates.
 * Assumes wr, reload and upd come from the same pclk domain.
 */
`timescale 1ns/100ps
`default_nettype none

module drs_buf #(
	parameter int W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	input  wire logic         active,
	input  wire logic         reload,
	input  wire logic         upd,
	input  wire logic [W-1:0] upd_val,
	output logic      [W-1:0] master_r,
	output logic      [W-1:0] slave_r
);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_r <= '0;
		end else if (wr) begin
			master_r <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// idle writes land in both stages; busy writes wait for the reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_r <= '0;
		end else if (wr && !active) begin
			slave_r <= wdata;
		end else if (reload) begin
			slave_r <= wr ? wdata : master_r;
		end else if (upd) begin
			slave_r <= upd_val;
		end
	end

endmodule

`default_nettype wire

// ---- verif/drs_dma_sva.sv ----
/* Port assertions for drs_dma, bound below the checker.
   Assumes one pclk domain and presetn active low. */
`timescale 1ns/100ps
`default_nettype none
module drs_dma_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_periph,
	input wire logic        cpu_ram_stall,
	input wire logic        cpu_periph_stall,
	input wire logic [3:0]  transfer_end_interrupt
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
logic       req_q, we_q, per_q;
logic [3:0] cnt_r, low_r;
logic [2:0] wait_r;
wire        apb_wr = psel && penable && pready && pwrite;
// a forced stop may cut an access short
wire        init_wr = apb_wr && paddr[4:0] == 5'h14 && pwdata[1];
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		req_q <= 1'b0;
		we_q  <= 1'b0;
		per_q <= 1'b0;
		cnt_r <= 4'h0;
		low_r <= 4'h0;
	end else begin
		req_q <= mem_req;
		we_q  <= mem_we;
		per_q <= mem_periph;
		if (!mem_req)
			cnt_r <= 4'h0;
		else if (req_q && mem_we == we_q)
			cnt_r <= cnt_r + 4'h1;
		else
			cnt_r <= 4'h1;
		// saturate so long idle spells do not wrap
		if (mem_req)
			low_r <= 4'h0;
		else if (low_r != 4'hf)
			low_r <= low_r + 4'h1;
	end
end
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn)
		wait_r <= 3'h0;
	else if (apb_wr && paddr == 12'h080)
		wait_r <= pwdata[2:0];
end
////////////////////////////////////////
sequence s_gap_write;
	!mem_req ##1 (mem_req && mem_we);
endsequence
chk_apb_wait: assert property (psel && !penable |=> pready)
	else $error("pready missing after setup");
chk_err_ready: assert property (pslverr |-> pready)
	else $error("pslverr without pready");
chk_resp_time: assert property (
	$rose(mem_req) && !mem_we |-> low_r >= 4'd4)
	else $error("read cycle started too early");
chk_acc_len: assert property (
	req_q && (!mem_req || mem_we != we_q) && !$past(init_wr) |->
	cnt_r == (per_q ? 4'd4 + {1'b0, wait_r} : 4'd2))
	else $error("access length wrong");
chk_gap_one: assert property (
	$fell(mem_req) && !$past(mem_we) && !$past(init_wr) |-> s_gap_write)
	else $error("read to write gap not one clock");
chk_lsb_zero: assert property (mem_req |-> !mem_addr[0])
	else $error("odd memory address");
chk_ram_stall: assert property (
	mem_req && !mem_periph |-> cpu_ram_stall)
	else $error("ram stall missing");
chk_peri_stall: assert property (
	mem_req && mem_periph |-> cpu_periph_stall)
	else $error("peripheral stall missing");
chk_end_pulse: assert property (
	|transfer_end_interrupt |-> $past(mem_req) && $past(mem_we) &&
	!mem_req ##1 transfer_end_interrupt == 4'h0)
	else $error("end interrupt misplaced");
chk_init_abort: assert property (
	init_wr |=> !mem_req)
	else $error("transfer not stopped");
endmodule
bind drs_dma drs_dma_sva chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_periph(mem_periph), .cpu_ram_stall(cpu_ram_stall),
	.cpu_periph_stall(cpu_periph_stall),
	.transfer_end_interrupt(transfer_end_interrupt));
`default_nettype wire

// ---- verif/drs_mem_model.sv ----
/* RAM and peripheral space behind the engine's memory port.
   Assumes the engine holds address and direction for a whole access. */
`timescale 1ns/100ps
`default_nettype none
module drs_mem_model (
	input wire logic        pclk,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	output var logic [15:0] mem_rdata
);
initial mem_rdata = 16'h0000;
// no handshake: data is ready from the second access cycle
always @(posedge pclk) begin
	if (mem_req && !mem_we)
		mem_rdata <= mem_addr[15:0] ^ 16'h5a5a;
	else
		mem_rdata <= ~mem_rdata;
end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
/* Self-checking bench for drs_dma with a queue model of the writes.
   Assumes drs_mem_model returns address xor 5a5a on every read. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
localparam int NZ = 2;
logic        pclk = 1'b0, presetn = 1'b0;
logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, rng = 32'h6bd8_a34e;
logic [31:0] prdata, rdv, mem_addr;
logic        pready, pslverr, erv, mem_req, mem_we, ws = 1'b0;
logic [63:0] periph_irq = 64'h0;
logic [1:0]  xpin = 2'b00;
logic [15:0] mem_wdata, mem_rdata;
logic [3:0]  tei, seen = 4'h0;
logic [47:0] exp_q[$];
int          n_errors = 0, check_count = 0, cyc = 0;
always #25 pclk = ~pclk;
drs_dma #(.NOISE_CLKS(NZ)) dut_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .periph_irq(periph_irq),
	.external_pin_interrupt(xpin), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_periph(),
	.mem_rdata(mem_rdata), .cpu_ram_stall(), .cpu_periph_stall(),
	.transfer_end_interrupt(tei));
drs_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_rdata(mem_rdata));
////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] x);
	logic [31:0] y;
	y = x ^ (x << 13);
	y = y ^ (y >> 17);
	return y ^ (y << 5);
endfunction
task automatic give_verdict;
	$display("checks %0d errors %0d", check_count, n_errors);
	if (n_errors == 0 && check_count > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
	check_count++;
	if (got !== exp) begin
		n_errors++;
		$display("wrong value at %0t: got %h want %h", $time, got, exp);
	end
endtask
task automatic apb(input logic w, input logic [11:0] a,
	input logic [31:0] d);
	int t;
	t = 0;
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	@(posedge pclk);
	// ready and data are taken at the completing edge only
	while (pready !== 1'b1 && t < 16) begin
		@(posedge pclk);
		t++;
	end
	if (t == 16)
		n_errors++;
	rdv = prdata;
	erv = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge pclk);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e,
	input logic [31:0] m);
	apb(1'b0, a, 32'h0);
	cmp({16'h0, rdv & m}, {16'h0, e});
endtask
task automatic expect_units(input logic [31:0] s, d, input int n);
	logic [31:0] sa;
	logic [31:0] da;
	sa = s & 32'hffff_fffe;
	da = d & 32'hffff_fffe;
	repeat (n) begin
		exp_q.push_back({da, sa[15:0] ^ 16'h5a5a});
		sa = sa + 32'h2;
		da = da + 32'h2;
	end
endtask
task automatic wait_end(input int ch);
	int t;
	t = 0;
	while (!seen[ch] && t < 300) begin
		@(posedge pclk);
		t++;
	end
	cmp({47'h0, seen[ch]}, 48'h1);
	cmp(48'(exp_q.size()), 48'h0);
	seen = 4'h0;
endtask
// writes are judged at their first cycle, against the model queue
always @(negedge pclk) begin
	cyc++;
	seen = seen | tei;
	if (mem_req && mem_we && !ws) begin
		if (exp_q.size() == 0)
			cmp(48'h0, 48'h1);
		else
			cmp({mem_addr, mem_wdata}, exp_q.pop_front());
	end
	ws = mem_req && mem_we;
	if (cyc > 8000) begin
		n_errors++;
		give_verdict;
	end
end
////////////////////////////////////////
initial begin
	logic [31:0] s;
	int t;
	repeat (16) @(posedge pclk);
	presetn <= 1'b1;
	@(posedge pclk);
	for (int i = 0; i < 8; i++)
		rd(12'(4 * i), 32'h0, 32'hffff_ffff);
	apb(1'b0, 12'h0fc, 32'h0);
	cmp({47'h0, erv}, 48'h1);
	cmp({16'h0, rdv}, 48'h0);
	// block run on channel 0 from a random odd source
	rng = xs(rng);
	s = {16'h0, rng[15:0] | 16'h0001};
	apb(1'b1, 12'h004, s);
	apb(1'b1, 12'h00c, 32'h4001);
	apb(1'b1, 12'h010, 32'h3);
	rd(12'h010, 32'h3, 32'hffff);
	apb(1'b1, 12'h018, 32'h40);
	expect_units(s, 32'h4001, 3);
	apb(1'b1, 12'h014, 32'h5);
	apb(1'b1, 12'h000, 32'h1);
	wait_end(0);
	rd(12'h000, 32'h1, 32'hffff);
	rd(12'h014, 32'h8, 32'h8);
	rd(12'h014, 32'h0, 32'h8);
	rd(12'h014, 32'h0, 32'h8);
	// channel 1, peripheral source, select zero then code 9
	apb(1'b1, 12'h080, 32'h2);
	apb(1'b1, 12'h024, 32'h100);
	apb(1'b1, 12'h02c, 32'h6000);
	apb(1'b1, 12'h030, 32'h1);
	apb(1'b1, 12'h038, 32'h10);
	apb(1'b1, 12'h034, 32'h1);
	repeat (8) begin
		rng = xs(rng);
		periph_irq <= {rng, xs(rng)};
		@(posedge pclk);
	end
	periph_irq <= 64'h0;
	repeat (20) @(posedge pclk);
	apb(1'b1, 12'h03c, 32'h9);
	expect_units(32'h100, 32'h6000, 1);
	periph_irq <= 64'h200;
	@(posedge pclk);
	periph_irq <= 64'h0;
	wait_end(1);
	// channel 2 from pin 0 through the noise filter
	apb(1'b1, 12'h04c, 32'h7000);
	apb(1'b1, 12'h050, 32'h1);
	apb(1'b1, 12'h05c, {26'h0, drs_pkg::EXT_CODE0});
	apb(1'b1, 12'h054, 32'h1);
	expect_units(32'h0, 32'h7000, 1);
	xpin <= 2'b01;
	t = 0;
	while (mem_req !== 1'b1 && t < 40) begin
		@(negedge pclk);
		t++;
	end
	cmp({47'h0, t >= 4 + NZ && t < 40}, 48'h1);
	@(posedge pclk);
	xpin <= 2'b00;
	wait_end(2);
	// channel 3: one single unit, reprogram, then forced stop
	apb(1'b1, 12'h064, 32'h200);
	apb(1'b1, 12'h06c, 32'h8000);
	apb(1'b1, 12'h070, 32'h3);
	apb(1'b1, 12'h07c, 32'hc);
	apb(1'b1, 12'h074, 32'h1);
	expect_units(32'h200, 32'h8000, 1);
	periph_irq <= 64'h1000;
	@(posedge pclk);
	periph_irq <= 64'h0;
	t = 0;
	while (exp_q.size() != 0 && t < 60) begin
		@(posedge pclk);
		t++;
	end
	apb(1'b1, 12'h064, 32'h400);
	rd(12'h064, 32'h202, 32'hffff);
	// second unit is stopped inside its read access, so no write follows
	periph_irq <= 64'h1000;
	@(posedge pclk);
	periph_irq <= 64'h0;
	repeat (4) @(posedge pclk);
	apb(1'b1, 12'h074, 32'h3);
	rd(12'h064, 32'h400, 32'hffff);
	rd(12'h074, 32'h0, 32'h8);
	repeat (20) @(posedge pclk);
	cmp({44'h0, seen}, 48'h0);
	give_verdict;
end
endmodule
`default_nettype wire
